// File: shared/pfm_defines.svh
// constants for the program flash access controller
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH
`define PFM_WORD_W        14
`define PFM_ADDR_W        15
`define PFM_ROW_WORDS     32
`define PFM_ROW_BITS      5
`define PFM_USER_WORDS    16384
`define PFM_DEPTH         16416
`define PFM_LAST_ADDR     15'h401F
`define PFM_EXTRA_BASE    15'h4000
`define PFM_CFG_FIRST     15'h4007
`define PFM_CFG3_ADDR     15'h4009
`define PFM_CFG4_ADDR     15'h400A
`define PFM_WRT_LSB       0
`define PFM_CP_BIT        0
`define PFM_CPD_BIT       1
`define PFM_ERASED        14'h3FFF
`define PFM_WRT_HALF_END  15'h2000
`define PFM_WRT_BOOT_END  15'h0200
`define PFM_CLK_NS        25
`define PFM_T_WRITE_US    2000
`define PFM_T_ERASE_US    2000
`define PFM_T_BULK_US     5000
`endif

// File: shared/pfm_pkg.sv
// types of the program flash access controller
package pfm_pkg;
   typedef enum logic [2:0] {
      PFM_CMD_READ  = 3'h0,
      PFM_CMD_LOAD  = 3'h1,
      PFM_CMD_WRITE = 3'h2,
      PFM_CMD_ERASE = 3'h3,
      PFM_CMD_BULK  = 3'h4
   } pfm_cmd_e;
   typedef enum logic [3:0] {
      PFM_S_CFG   = 4'h1,
      PFM_S_IDLE  = 4'h2,
      PFM_S_SWEEP = 4'h4,
      PFM_S_TIME  = 4'h8
   } pfm_state_e;
endpackage

// File: src/pfm_nvm_ctl.sv
// program flash array with fetch, indirect, firmware and programmer access
`include "pfm_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module pfm_nvm_ctl
   import pfm_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES =
      (`PFM_T_WRITE_US * 1000 + `PFM_CLK_NS - 1) / `PFM_CLK_NS,
   parameter int unsigned ERASE_CYCLES =
      (`PFM_T_ERASE_US * 1000 + `PFM_CLK_NS - 1) / `PFM_CLK_NS,
   parameter int unsigned BULK_CYCLES  =
      (`PFM_T_BULK_US * 1000 + `PFM_CLK_NS - 1) / `PFM_CLK_NS
)(
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   // instruction fetch
   input  wire logic        i_fetch_req,
   input  wire logic [13:0] i_fetch_addr,
   output logic             o_fetch_valid,
   output logic      [13:0] o_fetch_data,
   // indirect pointer reads
   input  wire logic        i_ind_req,
   input  wire logic [13:0] i_ind_addr,
   output logic             o_ind_valid,
   output logic      [13:0] o_ind_data,
   // nvm register interface
   input  wire logic        i_nvm_cmd_valid,
   input  pfm_cmd_e         i_nvm_cmd,
   input  wire logic [14:0] i_nvm_addr,
   input  wire logic [5:0]  i_nvm_data_high,
   input  wire logic [7:0]  i_nvm_data_low,
   output logic             o_nvm_done,
   output logic             o_nvm_error,
   output logic      [13:0] o_nvm_rdata,
   // external programmer
   input  wire logic        i_prog_cmd_valid,
   input  pfm_cmd_e         i_prog_cmd,
   input  wire logic [14:0] i_prog_addr,
   input  wire logic [13:0] i_prog_data,
   output logic             o_prog_done,
   output logic             o_prog_refused,
   output logic      [13:0] o_prog_rdata,
   // status
   output logic             o_busy,
   output logic             o_program_read_protect,
   output logic             o_eeprom_read_protect
);
   localparam int unsigned TW = 20;
   // main array: user words then one extra row for IDs and config
   logic [13:0] mem [`PFM_DEPTH];
   pfm_state_e  state, next_state;
   pfm_cmd_e    op, next_op;
   logic        src_prog, next_src_prog;
   logic [14:0] base, next_base;
   logic [14:0] idx, next_idx;
   logic        prot_cp, next_prot_cp;
   logic        prot_cpd, next_prot_cpd;
   logic [1:0]  self_write_protect_range, next_wrt;
   logic        next_busy;
   logic        next_nvm_done, next_nvm_error;
   logic        next_prog_done, next_prog_refused;
   logic [13:0] next_nvm_rdata, next_prog_rdata;
   logic        mem_we;
   logic [14:0] sw_addr;
   logic [13:0] mem_wdata;
   logic        timer_start, timer_done;
   logic [TW-1:0] timer_load;
   logic        latch_load, latch_clear;
   logic [13:0] latch_data, latch_word;
   logic        sel_prog, c_bad, fw_clash;
   pfm_cmd_e    c_cmd;
   logic [14:0] c_addr;
   function automatic logic wrt_hit(input logic [1:0] r, input logic [14:0] a);
      logic hit;
      hit = 1'b0;
      case (r)
         2'b11:   hit = 1'b0;
         2'b10:   hit = (a < `PFM_WRT_BOOT_END);
         2'b01:   hit = (a < `PFM_WRT_HALF_END);
         default: hit = (a < `PFM_EXTRA_BASE);
      endcase
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   pfm_write_latches #(.WORDS(`PFM_ROW_WORDS), .WIDTH(`PFM_WORD_W), .IW(`PFM_ROW_BITS)) u_latches (
      .i_clock     (i_clock),
      .i_arst_n    (i_arst_n),
      .i_load      (latch_load),
      .i_load_idx  (c_addr[4:0]),
      .i_load_data (latch_data),
      .i_clear     (latch_clear),
      .i_rd_idx    (idx[4:0]),
      .o_rd_data   (latch_word)
   );
   pfm_timer #(.W(TW)) u_timer (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .i_start  (timer_start),
      .i_load   (timer_load),
      .o_done   (timer_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command decode; programmer wins a same-cycle clash
   always_comb begin
      sel_prog   = i_prog_cmd_valid;
      fw_clash   = i_nvm_cmd_valid && i_prog_cmd_valid;
      c_cmd      = sel_prog ? i_prog_cmd : i_nvm_cmd;
      c_addr     = sel_prog ? i_prog_addr : i_nvm_addr;
      latch_data = sel_prog ? i_prog_data : {i_nvm_data_high, i_nvm_data_low};
      c_bad      = (c_addr > `PFM_LAST_ADDR) && (c_cmd != PFM_CMD_BULK);
      if (sel_prog) begin
         c_bad = c_bad || (prot_cp && (c_cmd != PFM_CMD_BULK));
      end else begin
         c_bad = c_bad || (c_cmd == PFM_CMD_BULK);
         c_bad = c_bad || ((c_cmd == PFM_CMD_WRITE || c_cmd == PFM_CMD_ERASE)
                           && wrt_hit(self_write_protect_range, c_addr));
         // the extra row carries config, so firmware never erases it
         c_bad = c_bad || ((c_cmd == PFM_CMD_ERASE) && (c_addr >= `PFM_EXTRA_BASE));
      end
   end

   // row erase and write cover one row; bulk sweeps the whole array
   always_comb begin
      sw_addr = (op == PFM_CMD_BULK) ? idx
                : {base[14:`PFM_ROW_BITS], idx[`PFM_ROW_BITS-1:0]};
      mem_wdata = (op == PFM_CMD_WRITE) ? (mem[sw_addr] & latch_word)
                  : `PFM_ERASED;
      mem_we = (state == PFM_S_SWEEP)
               && !(!src_prog && (sw_addr >= `PFM_CFG_FIRST));
   end

   ////////////////////////////////////////////////////////////////////////////
   // control machine
   always_comb begin
      next_state        = state;
      next_op           = op;
      next_src_prog     = src_prog;
      next_base         = base;
      next_idx          = idx;
      next_prot_cp      = prot_cp;
      next_prot_cpd     = prot_cpd;
      next_wrt          = self_write_protect_range;
      next_nvm_done     = 1'b0;
      next_nvm_error    = i_nvm_cmd_valid && (state != PFM_S_IDLE || fw_clash);
      next_prog_done    = 1'b0;
      next_prog_refused = i_prog_cmd_valid && (state != PFM_S_IDLE);
      next_nvm_rdata    = o_nvm_rdata;
      next_prog_rdata   = o_prog_rdata;
      timer_start       = 1'b0;
      timer_load        = TW'(WRITE_CYCLES);
      latch_load        = 1'b0;
      latch_clear       = 1'b0;
      case (state)
         PFM_S_CFG: begin
            // protection bits are active low so an erased part is open
            next_prot_cp  = !mem[`PFM_CFG4_ADDR][`PFM_CP_BIT];
            next_prot_cpd = !mem[`PFM_CFG4_ADDR][`PFM_CPD_BIT];
            next_wrt      = mem[`PFM_CFG3_ADDR][`PFM_WRT_LSB +: 2];
            next_state    = PFM_S_IDLE;
         end
         PFM_S_IDLE: begin
            if ((i_prog_cmd_valid || i_nvm_cmd_valid) && c_bad) begin
               next_prog_refused = sel_prog;
               next_nvm_error    = !sel_prog || fw_clash;
            end else if (i_prog_cmd_valid || i_nvm_cmd_valid) begin
               case (c_cmd)
                  PFM_CMD_READ: begin
                     next_prog_rdata = sel_prog ? mem[c_addr] : o_prog_rdata;
                     next_nvm_rdata  = sel_prog ? o_nvm_rdata : mem[c_addr];
                     next_prog_done  = sel_prog;
                     next_nvm_done   = !sel_prog;
                  end
                  PFM_CMD_LOAD: begin
                     latch_load     = 1'b1;
                     next_prog_done = sel_prog;
                     next_nvm_done  = !sel_prog;
                  end
                  default: begin
                     next_op       = c_cmd;
                     next_src_prog = sel_prog;
                     next_base     = (c_cmd == PFM_CMD_BULK) ? '0 : c_addr;
                     next_idx      = '0;
                     next_state    = PFM_S_SWEEP;
                  end
               endcase
            end
         end
         PFM_S_SWEEP: begin
            next_idx = idx + 15'h0001;
            if ((op == PFM_CMD_BULK) ? (idx == `PFM_LAST_ADDR)
                : (idx[4:0] == 5'h1F)) begin
               timer_start = 1'b1;
               timer_load  = (op == PFM_CMD_WRITE) ? TW'(WRITE_CYCLES)
                             : (op == PFM_CMD_ERASE) ? TW'(ERASE_CYCLES)
                             : TW'(BULK_CYCLES);
               next_state  = PFM_S_TIME;
            end
         end
         PFM_S_TIME: begin
            if (timer_done) begin
               next_prog_done = src_prog;
               next_nvm_done  = !src_prog;
               latch_clear    = (op == PFM_CMD_WRITE);
               // bulk erase wiped config, so protection is read back
               next_state     = (op == PFM_CMD_BULK) ? PFM_S_CFG : PFM_S_IDLE;
            end
         end
         default: next_state = PFM_S_CFG;
      endcase
      next_busy = (next_state != PFM_S_IDLE);
   end
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state                    <= PFM_S_CFG;
         op                       <= PFM_CMD_READ;
         src_prog                 <= 1'b0;
         base                     <= '0;
         idx                      <= '0;
         prot_cp                  <= 1'b1;
         prot_cpd                 <= 1'b1;
         self_write_protect_range <= 2'h0;
         o_busy                   <= 1'b1;
         o_nvm_done               <= 1'b0;
         o_nvm_error              <= 1'b0;
         o_prog_done              <= 1'b0;
         o_prog_refused           <= 1'b0;
         o_nvm_rdata              <= 14'h0000;
         o_prog_rdata             <= 14'h0000;
         o_program_read_protect   <= 1'b1;
         o_eeprom_read_protect    <= 1'b1;
      end else begin
         state                    <= next_state;
         op                       <= next_op;
         src_prog                 <= next_src_prog;
         base                     <= next_base;
         idx                      <= next_idx;
         prot_cp                  <= next_prot_cp;
         prot_cpd                 <= next_prot_cpd;
         self_write_protect_range <= next_wrt;
         o_busy                   <= next_busy;
         o_nvm_done               <= next_nvm_done;
         o_nvm_error              <= next_nvm_error;
         o_prog_done              <= next_prog_done;
         o_prog_refused           <= next_prog_refused;
         o_nvm_rdata              <= next_nvm_rdata;
         o_prog_rdata             <= next_prog_rdata;
         o_program_read_protect   <= next_prot_cp;
         o_eeprom_read_protect    <= next_prot_cpd;
      end
   end
   // array contents survive reset; a fresh part starts erased
   initial begin
      for (int i = 0; i < `PFM_DEPTH; i++) begin
         mem[i] = `PFM_ERASED;
      end
   end
   always @(posedge i_clock) begin
      if (mem_we) begin
         mem[sw_addr] <= mem_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read-only ports; refused while a sweep or timed phase owns the array
   logic        next_fetch_valid, next_ind_valid;
   logic [13:0] next_fetch_data, next_ind_data;
   always_comb begin
      next_fetch_valid = i_fetch_req && (state == PFM_S_IDLE);
      next_ind_valid   = i_ind_req && (state == PFM_S_IDLE);
      next_fetch_data  = next_fetch_valid ? mem[i_fetch_addr] : o_fetch_data;
      next_ind_data    = next_ind_valid ? mem[i_ind_addr] : o_ind_data;
   end
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_fetch_valid <= 1'b0;
         o_ind_valid   <= 1'b0;
         o_fetch_data  <= 14'h0000;
         o_ind_data    <= 14'h0000;
      end else begin
         o_fetch_valid <= next_fetch_valid;
         o_ind_valid   <= next_ind_valid;
         o_fetch_data  <= next_fetch_data;
         o_ind_data    <= next_ind_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   erase_ones_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      mem_we && op != PFM_CMD_WRITE |-> mem_wdata == 14'h3FFF)
      else $error("erase wrote a zero bit");
   program_clears_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      mem_we && op == PFM_CMD_WRITE |-> (mem_wdata & ~mem[sw_addr]) == 14'h0000)
      else $error("program set a bit");
   row_bound_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      mem_we && op != PFM_CMD_BULK |-> sw_addr[14:5] == base[14:5])
      else $error("row sweep left its row");
   fetch_single_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_fetch_valid |-> $past(i_fetch_req) && $past(state) == PFM_S_IDLE)
      else $error("fetch answer without request");
   write_owner_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      mem_we |-> state == PFM_S_SWEEP && op != PFM_CMD_READ && op != PFM_CMD_LOAD)
      else $error("array written outside a sweep");
   cp_refuse_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state == PFM_S_IDLE && i_prog_cmd_valid && prot_cp && i_prog_cmd != PFM_CMD_BULK
      |=> o_prog_refused && !o_prog_done && state == PFM_S_IDLE)
      else $error("protected programmer access taken");
   wrt_block_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state == PFM_S_IDLE && i_nvm_cmd_valid && !i_prog_cmd_valid
      && i_nvm_cmd == PFM_CMD_ERASE && wrt_hit(self_write_protect_range, i_nvm_addr)
      |=> o_nvm_error && state == PFM_S_IDLE)
      else $error("protected self erase taken");
   fw_bulk_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state == PFM_S_IDLE && i_nvm_cmd_valid && !i_prog_cmd_valid && i_nvm_cmd == PFM_CMD_BULK
      |=> o_nvm_error ##1 !o_busy)
      else $error("firmware bulk erase taken");
   timed_end_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state == PFM_S_SWEEP && next_state == PFM_S_TIME |=> (state == PFM_S_TIME && o_busy)[*2])
      else $error("timed phase cut short");
   bulk_unlock_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state == PFM_S_TIME && timer_done && op == PFM_CMD_BULK |=> ##1 !prot_cp && !o_program_read_protect)
      else $error("bulk erase left protection set");
endmodule

// File: src/pfm_timer.sv
// down counter that times one write or erase
module pfm_timer #(
   parameter int unsigned W = 20
)(
   // clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_arst_n,
   // control
   input  wire logic         i_start,
   input  wire logic [W-1:0] i_load,
   // status
   output logic              o_done
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         next_done;

   always_comb begin
      next_count = count;
      next_done  = 1'b0;
      if (i_start) begin
         next_count = i_load;
      end else if (count != '0) begin
         next_count = count - 1'b1;
         next_done  = (count == {{(W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count  <= '0;
         o_done <= 1'b0;
      end else begin
         count  <= next_count;
         o_done <= next_done;
      end
   end
endmodule

// File: src/pfm_write_latches.sv
// row of hidden write latches, erased value when not loaded
module pfm_write_latches #(
   parameter int unsigned WORDS = 32,
   parameter int unsigned WIDTH = 14,
   parameter int unsigned IW    = 5
)(
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_arst_n,
   // loading
   input  wire logic             i_load,
   input  wire logic [IW-1:0]    i_load_idx,
   input  wire logic [WIDTH-1:0] i_load_data,
   input  wire logic             i_clear,
   // readout
   input  wire logic [IW-1:0]    i_rd_idx,
   output logic      [WIDTH-1:0] o_rd_data
);
   logic [WIDTH-1:0] word      [WORDS];
   logic [WIDTH-1:0] next_word [WORDS];

   // unloaded latches stay all ones, so a partial row leaves other words alone
   always_comb begin
      for (int i = 0; i < WORDS; i++) begin
         next_word[i] = word[i];
         if (i_clear) begin
            next_word[i] = '1;
         end else if (i_load && (i_load_idx == IW'(i))) begin
            next_word[i] = i_load_data;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < WORDS; i++) begin
            word[i] <= '1;
         end
      end else begin
         for (int i = 0; i < WORDS; i++) begin
            word[i] <= next_word[i];
         end
      end
   end

   assign o_rd_data = word[i_rd_idx];
endmodule

// File: testbench/pfm_host_model.sv
// firmware and programmer model driving the command ports
module pfm_host_model
   import pfm_pkg::*;
(
   // clock
   input  wire logic        i_clock,
   // firmware side
   output logic             o_nvm_cmd_valid,
   output pfm_cmd_e         o_nvm_cmd,
   output logic      [14:0] o_nvm_addr,
   output logic      [5:0]  o_nvm_data_high,
   output logic      [7:0]  o_nvm_data_low,
   input  wire logic        i_nvm_done,
   input  wire logic        i_nvm_error,
   input  wire logic [13:0] i_nvm_rdata,
   // programmer side
   output logic             o_prog_cmd_valid,
   output pfm_cmd_e         o_prog_cmd,
   output logic      [14:0] o_prog_addr,
   output logic      [13:0] o_prog_data,
   input  wire logic        i_prog_done,
   input  wire logic        i_prog_refused,
   input  wire logic [13:0] i_prog_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_nvm_cmd_valid = 1'b0;
      o_nvm_cmd = PFM_CMD_READ;
      o_nvm_addr = 15'h0000;
      {o_nvm_data_high, o_nvm_data_low} = 14'h0000;
      o_prog_cmd_valid = 1'b0;
      o_prog_cmd = PFM_CMD_READ;
      o_prog_addr = 15'h0000;
      o_prog_data = 14'h0000;
   end
   ////////////////////////////////////////
   // one command, held for one clock, then wait for its answer
   task automatic cmd(input bit prog, input pfm_cmd_e c, input logic [14:0] a, input logic [13:0] d,
                      output logic ok, output logic [13:0] rd, output int n);
      @(posedge i_clock);
      if (prog) begin
         o_prog_cmd_valid <= 1'b1;
         o_prog_cmd <= c;
         o_prog_addr <= a;
         o_prog_data <= d;
      end else begin
         o_nvm_cmd_valid <= 1'b1;
         o_nvm_cmd <= c;
         o_nvm_addr <= a;
         {o_nvm_data_high, o_nvm_data_low} <= d;
      end
      @(posedge i_clock);
      o_prog_cmd_valid <= 1'b0;
      o_nvm_cmd_valid <= 1'b0;
      // released address lines and programmer data flip so a late sample shows up
      o_prog_addr <= ~a;
      o_nvm_addr <= ~a;
      o_prog_data <= ~d;
      for (n = 0; n < 20000; n++) begin
         #1;
         if (prog ? (i_prog_done | i_prog_refused) : (i_nvm_done | i_nvm_error))
            break;
         @(posedge i_clock);
      end
      ok = prog ? i_prog_done : i_nvm_done;
      rd = prog ? i_prog_rdata : i_nvm_rdata;
   endtask
   // change a used word: save row, erase it, write it all back
   task automatic row_rewrite(input logic [9:0] row, input logic [4:0] idx, input logic [13:0] word);
      logic [13:0] save [0:31];
      logic        ok;
      logic [13:0] rd;
      int          n;
      for (int i = 0; i < 32; i++) begin
         cmd(1'b0, PFM_CMD_READ, {row, 5'(i)}, 14'h0000, ok, rd, n);
         save[i] = (5'(i) == idx) ? word : rd;
      end
      cmd(1'b0, PFM_CMD_ERASE, {row, 5'h00}, 14'h0000, ok, rd, n);
      for (int i = 0; i < 32; i++)
         cmd(1'b0, PFM_CMD_LOAD, {row, 5'(i)}, save[i], ok, rd, n);
      cmd(1'b0, PFM_CMD_WRITE, {row, 5'h00}, 14'h0000, ok, rd, n);
   endtask
endmodule

// File: testbench/test_program_flash_nvm_control.sv
// self-checking bench for the program flash access controller
module test_program_flash_nvm_control
   import pfm_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock, arst_n, fetch_req, ind_req, fetch_valid, ind_valid, ok, busy, prot, eprot;
   logic        nvm_cmd_valid, nvm_done, nvm_error, prog_cmd_valid, prog_done, prog_refused;
   logic [13:0] fetch_addr, ind_addr, fetch_data, ind_data, nvm_rdata, prog_rdata, prog_data, rd, word;
   pfm_cmd_e    nvm_cmd, prog_cmd;
   logic [14:0] nvm_addr, prog_addr;
   logic [5:0]  nvm_data_high;
   logic [7:0]  nvm_data_low;
   logic [9:0]  row;
   logic [13:0] mem [0:16415];
   logic [13:0] lat [0:31];
   int          error_cnt = 0, samples_checked = 0, cyc = 0, last_cyc, seed;
   pfm_nvm_ctl #(.WRITE_CYCLES(8), .ERASE_CYCLES(8), .BULK_CYCLES(8)) i_dut (
      .i_clock(clock), .i_arst_n(arst_n),
      .i_fetch_req(fetch_req), .i_fetch_addr(fetch_addr), .o_fetch_valid(fetch_valid), .o_fetch_data(fetch_data),
      .i_ind_req(ind_req), .i_ind_addr(ind_addr), .o_ind_valid(ind_valid), .o_ind_data(ind_data),
      .i_nvm_cmd_valid(nvm_cmd_valid), .i_nvm_cmd(nvm_cmd), .i_nvm_addr(nvm_addr),
      .i_nvm_data_high(nvm_data_high), .i_nvm_data_low(nvm_data_low),
      .o_nvm_done(nvm_done), .o_nvm_error(nvm_error), .o_nvm_rdata(nvm_rdata),
      .i_prog_cmd_valid(prog_cmd_valid), .i_prog_cmd(prog_cmd), .i_prog_addr(prog_addr), .i_prog_data(prog_data),
      .o_prog_done(prog_done), .o_prog_refused(prog_refused), .o_prog_rdata(prog_rdata),
      .o_busy(busy), .o_program_read_protect(prot), .o_eeprom_read_protect(eprot));
   pfm_host_model i_host (
      .i_clock(clock), .o_nvm_cmd_valid(nvm_cmd_valid), .o_nvm_cmd(nvm_cmd), .o_nvm_addr(nvm_addr),
      .o_nvm_data_high(nvm_data_high), .o_nvm_data_low(nvm_data_low),
      .i_nvm_done(nvm_done), .i_nvm_error(nvm_error), .i_nvm_rdata(nvm_rdata),
      .o_prog_cmd_valid(prog_cmd_valid), .o_prog_cmd(prog_cmd), .o_prog_addr(prog_addr),
      .o_prog_data(prog_data), .i_prog_done(prog_done), .i_prog_refused(prog_refused), .i_prog_rdata(prog_rdata));
   always #12.5 clock = ~clock;
   // ceiling well above the single bulk sweep
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         $display("ERROR %0t run timed out", $time);
         tally_and_finish();
      end
   end
   ////////////////////////////////////////
   task automatic cmp_word(input logic [13:0] got, input logic [13:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
   endtask
   // command through the host model, reference array follows
   task automatic run(input bit prog, input pfm_cmd_e c, input logic [14:0] a, input logic [13:0] d,
                      input logic exp);
      i_host.cmd(prog, c, a, d, ok, rd, last_cyc);
      cmp_bit(ok, exp);
      cmp_bit(prog ? prog_refused : nvm_error, !exp);
      cmp_bit(busy, exp && c == PFM_CMD_BULK);
      if (exp && c == PFM_CMD_READ)
         cmp_word(rd, mem[a]);
      if (exp && c == PFM_CMD_LOAD)
         lat[a[4:0]] = d;
      for (int i = 0; i < 32; i++) begin
         if (exp && c == PFM_CMD_WRITE)
            mem[{a[14:5], 5'(i)}] &= lat[i];
         if (exp && c == PFM_CMD_WRITE)
            lat[i] = 14'h3FFF;
         if (exp && c == PFM_CMD_ERASE)
            mem[{a[14:5], 5'(i)}] = 14'h3FFF;
      end
      if (exp && c == PFM_CMD_BULK)
         foreach (mem[i]) mem[i] = 14'h3FFF;
   endtask
   // fetch or indirect read: one pulse, one word
   task automatic rd_port(input logic ind, input logic [13:0] a);
      @(posedge clock);
      fetch_req <= ~ind;
      ind_req <= ind;
      fetch_addr <= a;
      ind_addr <= a;
      @(posedge clock);
      fetch_req <= 1'b0;
      ind_req <= 1'b0;
      fetch_addr <= ~a;
      ind_addr <= ~a;
      for (int n = 0; n < 4; n++) begin
         #1;
         if ((ind ? ind_valid : fetch_valid) === 1'b1)
            break;
         @(posedge clock);
      end
      cmp_bit(ind ? ind_valid : fetch_valid, 1'b1);
      cmp_word(ind ? ind_data : fetch_data, mem[a]);
      @(posedge clock);
      #1;
      cmp_bit(ind ? ind_valid : fetch_valid, 1'b0);
   endtask
   ////////////////////////////////////////
   initial begin
      seed = 92;
      clock = 1'b0;
      fetch_req = 1'b0;
      ind_req = 1'b0;
      fetch_addr = 14'h0000;
      ind_addr = 14'h0000;
      foreach (mem[i]) mem[i] = 14'h3FFF;
      foreach (lat[i]) lat[i] = 14'h3FFF;
      do_reset();
      rd_port(1'b0, 14'h0005);
      rd_port(1'b1, 14'h3FFF);
      run(1'b0, PFM_CMD_BULK, 15'h0000, 14'h0000, 1'b0);
      run(1'b0, PFM_CMD_READ, 15'h4020, 14'h0000, 1'b0);
      run(1'b1, PFM_CMD_READ, 15'h401F, 14'h0000, 1'b1);
      $display("test erased_reads done");
      row = 10'(16 + $unsigned($random(seed)) % 496);
      // second pass can only clear more bits
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 32; i++)
            if ($random(seed) & 1)
               run(1'b0, PFM_CMD_LOAD, {row, 5'(i)}, 14'($random(seed)), 1'b1);
         run(1'b0, PFM_CMD_WRITE, {row, 5'($random(seed))}, 14'h0000, 1'b1);
         cmp_bit(last_cyc inside {[36:50]}, 1'b1);
      end
      for (int i = 0; i < 32; i++) begin
         run(1'b0, PFM_CMD_READ, {row, 5'(i)}, 14'h0000, 1'b1);
         rd_port(i[0], {row[8:0], 5'(i)});
      end
      word = 14'($random(seed));
      i_host.row_rewrite(row, 5'h03, word);
      mem[{row, 5'h03}] = word;
      run(1'b0, PFM_CMD_READ, {row, 5'h03}, 14'h0000, 1'b1);
      rd_port(1'b0, {row[8:0], 5'h04});
      run(1'b0, PFM_CMD_ERASE, {row, 5'h1F}, 14'h0000, 1'b1);
      run(1'b0, PFM_CMD_READ, {row, 5'h03}, 14'h0000, 1'b1);
      $display("test row_write done");
      run(1'b1, PFM_CMD_LOAD, 15'h4009, 14'h3FFE, 1'b1);
      run(1'b1, PFM_CMD_LOAD, 15'h400A, 14'h3FFC, 1'b1);
      run(1'b1, PFM_CMD_WRITE, 15'h4000, 14'h0000, 1'b1);
      do_reset();
      cmp_bit(prot, 1'b1);
      cmp_bit(eprot, 1'b1);
      run(1'b1, PFM_CMD_READ, 15'h0000, 14'h0000, 1'b0);
      run(1'b0, PFM_CMD_ERASE, 15'h01FF, 14'h0000, 1'b0);
      run(1'b0, PFM_CMD_LOAD, 15'h0200, 14'h1234, 1'b1);
      run(1'b0, PFM_CMD_WRITE, 15'h0200, 14'h0000, 1'b1);
      rd_port(1'b1, 14'h0200);
      run(1'b1, PFM_CMD_BULK, 15'h0000, 14'h0000, 1'b1);
      repeat (3) @(posedge clock);
      #1;
      cmp_bit(prot, 1'b0);
      cmp_bit(eprot, 1'b0);
      run(1'b1, PFM_CMD_READ, 15'h0200, 14'h0000, 1'b1);
      $display("test protection done");
      tally_and_finish();
   end
endmodule
